// ---- shared/mcu_irq_regs.svh ----
/*
 Constants for the core interrupt enable and merge block: register
 addresses, field positions, reset values and entry addresses.
 Assumes an 8-bit special-function bus and an external bus with 16-bit addresses and 8-bit data.
*/
// Functional notes
// - The five standard sources keep fixed entry addresses 0023h, 001Bh, 0013h, 000Bh, 0003h, and reset enters at 0000h.
// - Enable bits 0..4 gate external 0, timer 0, external 1, timer 1 and serial, 1 enables, all reset to 0.
// - Bit 7 is a global gate that blocks all five standard requests to the core at 0, and bits 5 and 6 are reserved.
// - The enable register sits at special-function address A8h and also answers to an alias name.
// - All internal peripheral requests are ORed into the single external interrupt 0 request.
// - After reset external interrupt 0 is edge sensed until firmware changes the sense mode.
// - A vector register names the active internal source and encodes 60 vectors.
// - Any write to the vector register retires the current vector and loads the next, and it reads 00h when idle.
// - The vector is group in bits 7-4, source in bits 3-1 and a zero bit 0, group 8 highest.
// - Priority is fixed in hardware with vector 0x88 highest and 0x12 lowest.
`ifndef MCU_IRQ_REGS_SVH
`define MCU_IRQ_REGS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define SFR_IRQ_ENABLE    8'hA8
`define SFR_SENSE_CTRL    8'h88
`define XADDR_IRQ_VECTOR  16'hFF92

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_EXT0_EN       0
`define BIT_TIMER0_EN     1
`define BIT_EXT1_EN       2
`define BIT_TIMER1_EN     3
`define BIT_SERIAL_EN     4
`define BIT_GLOBAL_GATE   7
`define BIT_SENSE_EDGE    0

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_IRQ_ENABLE    8'h00
`define RST_SENSE_EDGE    1'b1
`define RST_VECTOR        8'h00

// ****************************************************************
// Vectors and entry addresses
// ****************************************************************
`define VEC_LOWEST        8'h12
`define VEC_HIGHEST       8'h88
`define NUM_VEC_SRC       60
`define ENTRY_RESET       16'h0000
`define ENTRY_EXT0        16'h0003
`define ENTRY_TIMER0      16'h000B
`define ENTRY_EXT1        16'h0013
`define ENTRY_TIMER1      16'h001B
`define ENTRY_SERIAL      16'h0023

`endif

// ---- shared/mcu_irq_pkg.sv ----
/*
 Types for the core interrupt enable and merge block.
 Assumes the constants header is included alongside.
*/
package mcu_irq_pkg;
   typedef logic [7:0]  irq_vector_t;
   typedef logic [5:0]  vec_index_t;
   typedef logic [15:0] entry_addr_t;
   typedef logic [59:0] vec_pending_t;
endpackage

// ---- rtl/irq_priority_encoder.sv ----
/*
 Fixed-priority encoder from pending internal sources to a vector.
 Assumes bit k of the pending set stands for vector 12h plus 2k.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mcu_irq_regs.svh"
module irq_priority_encoder
   import mcu_irq_pkg::*;
(
   input  wire  vec_pending_t pending,
   output irq_vector_t        vector
);

   // ****************************************************************
   // Encoder
   // ****************************************************************
   // Highest vector wins, so group outranks source
   function automatic irq_vector_t encode(input vec_pending_t p);
      irq_vector_t v;
      v = `RST_VECTOR;
      for (int k = 0; k < `NUM_VEC_SRC; k++)
      begin
         if (p[k])
         begin
            v = 8'(`VEC_LOWEST + 8'(2 * k));
         end
      end
      return v;
   endfunction

   always_comb
   begin
      vector = encode(pending);
   end

endmodule
`default_nettype wire

// ---- rtl/mcu_interrupt_enable_and_merge.sv ----
/*
 Interrupt enable register, standard source gating and entry address
 selection, and merging of internal requests into external interrupt 0
 with a vector register.
 Assumes requests and acknowledge come from logic on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mcu_irq_regs.svh"
module mcu_interrupt_enable_and_merge
   import mcu_irq_pkg::*;
(
   input  wire  logic         clk_sys,
   input  wire  logic         nrst,
   input  wire  logic [7:0]   sfrAddr,
   input  wire  logic         sfrWrEn,
   input  wire  logic [7:0]   sfrWrData,
   input  wire  logic         sfrRdEn,
   output logic [7:0]         sfrRdData,
   input  wire  logic [15:0]  xAddr,
   input  wire  logic         xWrEn,
   input  wire  logic         xRdEn,
   output logic [7:0]         xRdData,
   input  wire  vec_pending_t periphReq,
   input  wire  logic         timer0Req,
   input  wire  logic         ext1Req,
   input  wire  logic         timer1Req,
   input  wire  logic         serialReq,
   input  wire  logic         coreAck,
   output logic               peripheralIrqLineN,
   output logic               extIrq0EdgeMode,
   output logic               coreIrqReq,
   output entry_addr_t        coreEntryAddr
);

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0]   enableReg,   enableNext;
   logic         senseReg,    senseNext;
   vec_pending_t pendingReg,  pendingNext;
   irq_vector_t  vectorReg,   vectorNext;
   logic         lineNReg,    lineNNext;
   logic         lineDlyReg,  lineDlyNext;
   logic         edgeFlagReg, edgeFlagNext;
   logic         reqReg,      reqNext;
   entry_addr_t  entryReg,    entryNext;
   logic [7:0]   sfrRdReg,    sfrRdNext;
   logic [7:0]   xRdReg,      xRdNext;

   logic         retire;
   logic         ext0Active;
   logic [4:0]   stdReq;

   function automatic vec_index_t vecIndex(input irq_vector_t v);
      irq_vector_t d;
      d = 8'(v - `VEC_LOWEST);
      return d[6:1];
   endfunction

   irq_priority_encoder encoder
   (
      .pending (pendingNext),
      .vector  (vectorNext)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      enableNext = enableReg;
      senseNext  = senseReg;
      if (sfrWrEn && sfrAddr == `SFR_IRQ_ENABLE)
      begin
         enableNext = sfrWrData;
      end
      if (sfrWrEn && sfrAddr == `SFR_SENSE_CTRL)
      begin
         senseNext = sfrWrData[`BIT_SENSE_EDGE];
      end

      retire      = xWrEn && xAddr == `XADDR_IRQ_VECTOR;
      pendingNext = pendingReg;
      if (retire && vectorReg != `RST_VECTOR)
      begin
         pendingNext[vecIndex(vectorReg)] = 1'b0;
      end
      // New request wins over a retire in the same cycle
      pendingNext = pendingNext | periphReq;

      lineNNext   = ~(|pendingNext);
      lineDlyNext = lineNReg;

      ext0Active = senseReg ? edgeFlagReg : ~lineNReg;
      stdReq = {serialReq, timer1Req, ext1Req, timer0Req, ext0Active}
               & enableReg[`BIT_SERIAL_EN:`BIT_EXT0_EN]
               & {5{enableReg[`BIT_GLOBAL_GATE]}};

      reqNext   = |stdReq;
      entryNext = `ENTRY_RESET;
      // Standard fixed order, external 0 first
      if (stdReq[`BIT_EXT0_EN])
         entryNext = `ENTRY_EXT0;
      else if (stdReq[`BIT_TIMER0_EN])
         entryNext = `ENTRY_TIMER0;
      else if (stdReq[`BIT_EXT1_EN])
         entryNext = `ENTRY_EXT1;
      else if (stdReq[`BIT_TIMER1_EN])
         entryNext = `ENTRY_TIMER1;
      else if (stdReq[`BIT_SERIAL_EN])
         entryNext = `ENTRY_SERIAL;

      edgeFlagNext = edgeFlagReg;
      if (coreAck && reqReg && entryReg == `ENTRY_EXT0)
      begin
         edgeFlagNext = 1'b0;
      end
      if (lineDlyReg && !lineNReg)
      begin
         edgeFlagNext = 1'b1;
      end

      sfrRdNext = sfrRdReg;
      if (sfrRdEn)
      begin
         case (sfrAddr)
            `SFR_IRQ_ENABLE: sfrRdNext = enableReg;
            `SFR_SENSE_CTRL: sfrRdNext = {7'h0, senseReg};
            default:         sfrRdNext = 8'h00;
         endcase
      end
      xRdNext = xRdReg;
      if (xRdEn)
      begin
         xRdNext = (xAddr == `XADDR_IRQ_VECTOR) ? vectorReg : 8'h00;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         enableReg   <= `RST_IRQ_ENABLE;
         senseReg    <= `RST_SENSE_EDGE;
         pendingReg  <= '0;
         vectorReg   <= `RST_VECTOR;
         lineNReg    <= 1'b1;
         lineDlyReg  <= 1'b1;
         edgeFlagReg <= 1'b0;
         reqReg      <= 1'b0;
         entryReg    <= `ENTRY_RESET;
         sfrRdReg    <= 8'h00;
         xRdReg      <= 8'h00;
      end
      else
      begin
         enableReg   <= enableNext;
         senseReg    <= senseNext;
         pendingReg  <= pendingNext;
         vectorReg   <= vectorNext;
         lineNReg    <= lineNNext;
         lineDlyReg  <= lineDlyNext;
         edgeFlagReg <= edgeFlagNext;
         reqReg      <= reqNext;
         entryReg    <= entryNext;
         sfrRdReg    <= sfrRdNext;
         xRdReg      <= xRdNext;
      end
   end

   assign sfrRdData          = sfrRdReg;
   assign xRdData            = xRdReg;
   assign peripheralIrqLineN = lineNReg;
   assign extIrq0EdgeMode    = senseReg;
   assign coreIrqReq         = reqReg;
   assign coreEntryAddr      = entryReg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_gate_blocks_all: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      !enableReg[`BIT_GLOBAL_GATE] |=> !coreIrqReq)
      else $error("request passed a closed global gate");

   chk_serial_disabled: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      !enableReg[`BIT_SERIAL_EN] |=> coreEntryAddr != `ENTRY_SERIAL)
      else $error("disabled serial source selected");

   chk_ext0_first: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      enableReg[`BIT_GLOBAL_GATE] && enableReg[`BIT_EXT0_EN] && ext0Active
      |=> coreIrqReq && coreEntryAddr == `ENTRY_EXT0)
      else $error("external 0 not taken at 0003h");

   chk_enable_write: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      sfrWrEn && sfrAddr == `SFR_IRQ_ENABLE
      |=> enableReg == $past(sfrWrData))
      else $error("enable register write lost");

   chk_enable_read: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      sfrRdEn && sfrAddr == `SFR_IRQ_ENABLE
      |=> sfrRdData == $past(enableReg))
      else $error("enable register read wrong");

   chk_line_follows_req: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      periphReq != '0 |=> !peripheralIrqLineN)
      else $error("merged line not asserted");

   chk_line_releases: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      peripheralIrqLineN == (vectorReg == `RST_VECTOR))
      else $error("merged line disagrees with vector");

   chk_vector_shape: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      vectorReg[0] == 1'b0 && (vectorReg == `RST_VECTOR
         || (vectorReg >= `VEC_LOWEST && vectorReg <= `VEC_HIGHEST)))
      else $error("vector out of shape");

   chk_top_wins: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      periphReq[`NUM_VEC_SRC-1] |=> vectorReg == `VEC_HIGHEST)
      else $error("highest vector not chosen");

   chk_retire_clears: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      retire && vectorReg != `RST_VECTOR && !periphReq[vecIndex(vectorReg)]
      |=> !pendingReg[vecIndex($past(vectorReg))])
      else $error("retired vector still pending");

   chk_edge_sets_flag: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      lineDlyReg && !lineNReg |=> edgeFlagReg)
      else $error("falling edge not latched");

endmodule
`default_nettype wire

// ---- dv/mcu_core_model.sv ----
/*
 Core side model: takes the selected entry after a set delay.
 Assumes requests and acknowledge live on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module mcu_core_model
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        ackOn,
   input  wire logic [3:0]  ackDelay,
   input  wire logic        coreIrqReq,
   input  wire logic [15:0] coreEntryAddr,
   output var  logic        coreAck,
   output var  logic [15:0] lastEntry
);
   int waitCnt = 0;
   // Slow or prompt, set by ackDelay; one process drives both outputs
   always @(negedge clk_sys)
   begin
      coreAck <= 1'b0;
      waitCnt <= 0;
      if (!nrst)
      begin
         lastEntry <= 16'h0000;
      end
      else if (ackOn && coreIrqReq === 1'b1)
      begin
         waitCnt <= waitCnt + 1;
         if (waitCnt >= int'(ackDelay))
         begin
            coreAck <= 1'b1;
            lastEntry <= coreEntryAddr;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/test_mcu_interrupt_enable_and_merge.sv ----
/*
 Self-checking bench for the interrupt enable and merge block.
 Assumes the constants header is on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mcu_irq_regs.svh"
module test_mcu_interrupt_enable_and_merge
   import mcu_irq_pkg::*;
;
   logic clk_sys, nrst, sfrWrEn, sfrRdEn, xWrEn, xRdEn, coreAck, lineN, edgeMode, irqReq, ackOn;
   logic [7:0] sfrAddr, sfrWrData, sfrRdData, xRdData, rd;
   logic [15:0] xAddr, entry, lastEntry;
   logic [3:0] stdReq, ackDelay;
   vec_pending_t periphReq;
   int n_mismatch = 0, comparisons = 0, cycles = 0, k;
   int pend[$];
   logic [15:0] tbl[5] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023};
   mcu_interrupt_enable_and_merge dut (.clk_sys(clk_sys), .nrst(nrst), .sfrAddr(sfrAddr),
      .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
      .xAddr(xAddr), .xWrEn(xWrEn), .xRdEn(xRdEn), .xRdData(xRdData), .periphReq(periphReq),
      .timer0Req(stdReq[0]), .ext1Req(stdReq[1]), .timer1Req(stdReq[2]),
      .serialReq(stdReq[3]), .coreAck(coreAck), .peripheralIrqLineN(lineN),
      .extIrq0EdgeMode(edgeMode), .coreIrqReq(irqReq), .coreEntryAddr(entry));
   mcu_core_model coreModel (.clk_sys(clk_sys), .nrst(nrst), .ackOn(ackOn),
      .ackDelay(ackDelay), .coreIrqReq(irqReq), .coreEntryAddr(entry),
      .coreAck(coreAck), .lastEntry(lastEntry));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfrAddr = a;
      sfrWrData = d;
      sfrWrEn = 1'b1;
      cyc(1);
      sfrWrEn = 1'b0;
   endtask
   task automatic sfr_rd(input logic [7:0] a);
      sfrAddr = a;
      sfrRdEn = 1'b1;
      cyc(1);
      sfrRdEn = 1'b0;
      cyc(1);
      rd = sfrRdData;
   endtask
   task automatic x_acc(input logic wr, input logic [15:0] a);
      xAddr = a;
      xWrEn = wr;
      xRdEn = !wr;
      cyc(1);
      xWrEn = 1'b0;
      xRdEn = 1'b0;
      cyc(1);
      rd = xRdData;
   endtask
   // Model: highest vector pending wins
   function automatic int top_idx();
      int b = -1;
      foreach (pend[i]) if (b < 0 || pend[i] > pend[b]) b = i;
      return b;
   endfunction
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ****************************************************************
   // Clock, timeout and sequence
   // ****************************************************************
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Whole run needs well under 1000 cycles
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   initial
   begin
      {nrst, sfrWrEn, sfrRdEn, xWrEn, xRdEn, ackOn} = '0;
      {sfrAddr, sfrWrData, xAddr, stdReq, periphReq} = '0;
      ackDelay = 4'h0;
      void'($urandom(32'ha6bc));
      cyc(2);
      nrst = 1'b1;
      cyc(1);
      sfr_rd(8'ha8);
      check(rd, 16'h0000);
      x_acc(1'b0, 16'hff92);
      check(rd, 16'h0000);
      check(lineN, 16'h0001);
      check(edgeMode, 16'h0001);
      sfr_rd(8'h88);
      check(rd, 16'h0001);
      $display("reset test done");
      k = $urandom;
      sfr_wr(8'ha8, k[7:0]);
      sfr_rd(8'ha8);
      check(rd, k[7:0]);
      sfr_rd(8'h12);
      check(rd, 16'h0000);
      $display("register test done");
      for (int i = 1; i < 5; i++)
      begin
         sfr_wr(8'ha8, 8'h80 | 8'(1 << i));
         stdReq = 4'(1 << (i - 1));
         cyc(1);
         check(irqReq, 16'h0001);
         check(entry, tbl[i]);
         sfr_wr(8'ha8, 8'(1 << i));
         cyc(1);
         check(irqReq, 16'h0000);
         sfr_wr(8'ha8, 8'h80);
         cyc(1);
         check(irqReq, 16'h0000);
         stdReq = 4'h0;
      end
      sfr_wr(8'ha8, 8'h9e);
      stdReq = 4'hf;
      cyc(1);
      check(entry, tbl[1]);
      stdReq = 4'h0;
      $display("gating test done");
      k = $urandom_range(58, 0);
      periphReq[k] = 1'b1;
      periphReq[59] = 1'b1;
      pend = '{8'h12 + 2 * k, 8'h88};
      cyc(1);
      periphReq = '0;
      cyc(1);
      check(lineN, 16'h0000);
      x_acc(1'b1, 16'hff90);
      x_acc(1'b0, 16'hff93);
      check(rd, 16'h0000);
      while (pend.size() > 0)
      begin
         x_acc(1'b0, 16'hff92);
         check(rd, 16'(pend[top_idx()]));
         x_acc(1'b1, 16'hff92);
         pend.delete(top_idx());
         check(lineN, 16'(pend.size() == 0));
      end
      x_acc(1'b1, 16'hff92);
      x_acc(1'b0, 16'hff92);
      check(rd, 16'h0000);
      $display("vector test done");
      sfr_wr(8'ha8, 8'h81);
      ackDelay = 4'($urandom_range(6, 1));
      ackOn = 1'b1;
      periphReq[0] = 1'b1;
      cyc(1);
      periphReq = '0;
      cyc(12);
      check(lastEntry, tbl[0]);
      check(irqReq, 16'h0000);
      check(lineN, 16'h0000);
      sfr_wr(8'h88, 8'h00);
      cyc(1);
      check(edgeMode, 16'h0000);
      check(irqReq, 16'h0001);
      sfr_rd(8'h88);
      check(rd, 16'h0000);
      x_acc(1'b0, 16'hff92);
      check(rd, 16'h0012);
      x_acc(1'b1, 16'hff92);
      cyc(2);
      check(irqReq, 16'h0000);
      $display("external 0 test done");
      complete_run();
   end
endmodule
`default_nettype wire
